// File: itf_pkg.sv
// Package of constants and types for the instruction trace fault logic
package itf_pkg;
   // Mode and event bit positions inside a 7-bit group
   localparam int MODE_INSTR = 0;
   localparam int MODE_BRANCH = 1;
   localparam int MODE_CALL = 2;
   localparam int MODE_RETURN = 3;
   localparam int MODE_PRERET = 4;
   localparam int MODE_SUPER = 5;
   localparam int MODE_BKPT = 6;
   localparam int NUM_MODES = 7;
   // Trace-controls word layout: modes at 1..7, events at 17..23
   localparam int TC_MODE_LSB = 1;
   localparam int TC_EVENT_LSB = 17;
   // Frame register bit positions
   localparam int FRAME_TRACE_BIT = 0;
   localparam int FRAME_PRERET_BIT = 3;
   // Supervisor stack word trace-control bit
   localparam int SSP_TRACE_BIT = 0;
   // Table entry type for a supervisor procedure
   localparam logic [1:0] ENTRY_SUPER = 2'h3;
   // Return-status values that mark a return from supervisor mode
   localparam logic [2:0] RSTAT_SUPER_A = 3'h2;
   localparam logic [2:0] RSTAT_SUPER_B = 3'h3;
   // Number of breakpoint registers
   localparam int NUM_BKPT = 2;
   localparam logic [6:0] FLAGS_ZERO = 7'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Retired-instruction description from the execution unit
   typedef struct packed {
      logic valid;            // One instruction retires this cycle
      logic [31:0] ip;        // Its instruction pointer
      logic branch_taken;     // Plain branch that branched
      logic call;             // Local or extended call
      logic call_sys;         // System call
      logic [1:0] entry_type; // Table entry type of a system call
      logic bal;              // Branch-and-link
      logic implicit_call;    // Entry to a fault or interrupt handler
      logic ret;              // Return instruction
      logic [2:0] ret_status; // Return-status of the frame being left
      logic frame_preret;     // Prereturn flag of the frame being left
      logic mark;             // Plain marker instruction
      logic fmark;            // Forced marker instruction
   } itf_instr_s;

   // Trace-control word write from software
   typedef struct packed {
      logic valid;       // Write strobe
      logic [31:0] mask; // Bits to modify
      logic [31:0] data; // New values of modified bits
   } itf_tcw_s;

   // Event flag group
   typedef logic [6:0] itf_flags_t;

   // Boundary-check state
   typedef enum logic [1:0] {ITF_IDLE, ITF_PRERET} itf_state_e;
endpackage

// File: itf_event_detect.sv
// Combinational trace event classifier for one retired instruction
module itf_event_detect
   import itf_pkg::*;
(
   input wire itf_instr_s instr,        // Retiring instruction
   input wire itf_flags_t modes,        // Enabled trace modes
   input wire logic bkpt_hit,           // Breakpoint register match
   output itf_flags_t events,           // Events raised, non-prereturn
   output logic preret_event,           // Prereturn event before return
   output logic set_frame_preret        // Set prereturn flag in frame
);
   logic sys_super;
   // Classify the instruction into event flags
   always_comb begin
      sys_super = instr.call_sys && (instr.entry_type == ENTRY_SUPER);
      events = FLAGS_ZERO;
      preret_event = 1'b0;
      set_frame_preret = 1'b0;
      if (instr.valid) begin
         events[MODE_INSTR] = modes[MODE_INSTR]; // see [RULE6]
         events[MODE_BRANCH] = modes[MODE_BRANCH] && instr.branch_taken; // see [RULE7]
         events[MODE_CALL] = modes[MODE_CALL]
            && (instr.call || instr.call_sys || instr.bal); // see [RULE8]
         events[MODE_RETURN] = modes[MODE_RETURN] && instr.ret; // see [RULE11]
         events[MODE_SUPER] = modes[MODE_SUPER] && (sys_super || (instr.ret
            && (instr.ret_status == RSTAT_SUPER_A
            || instr.ret_status == RSTAT_SUPER_B))); // see [RULE14]
         events[MODE_BKPT] = instr.fmark
            || (modes[MODE_BKPT] && (instr.mark || bkpt_hit)); // see [RULE15] [RULE16] [RULE17]
         preret_event = modes[MODE_PRERET] && instr.ret && instr.frame_preret; // see [RULE12]
      end
      // Implicit handler entry counts as a call
      if (instr.implicit_call && modes[MODE_CALL]) begin
         events[MODE_CALL] = 1'b1; // see [RULE9]
      end
      set_frame_preret = events[MODE_CALL]; // see [RULE10]
   end
endmodule

// File: itf_bkpt_regs.sv
// Two breakpoint registers loaded by interprocessor message
module itf_bkpt_regs
   import itf_pkg::*;
(
   input wire logic clock,            // Processor clock
   input wire logic rst_n,            // Synchronous reset, active low
   input wire logic msg_valid,        // Message strobe
   input wire logic msg_sel,          // Which breakpoint register
   input wire logic [31:0] msg_ip,    // Pointer to load
   input wire logic [31:0] ip,        // Pointer to compare
   output logic hit                   // Match against either register
);
   logic [31:0] bkpt [NUM_BKPT];      // Breakpoint storage
   logic [NUM_BKPT-1:0] armed;        // Register holds a loaded pointer
   // Load a breakpoint by message
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bkpt[0] <= WORD_ZERO;
         bkpt[1] <= WORD_ZERO;
         armed <= '0;
      end else if (msg_valid) begin
         bkpt[msg_sel] <= msg_ip; // see [RULE17]
         armed[msg_sel] <= 1'b1;
      end
   end
   // Compare the retiring pointer
   always_comb begin
      hit = (armed[0] && bkpt[0] == ip) || (armed[1] && bkpt[1] == ip); // see [RULE17]
   end
endmodule

// File: itf_trace_unit.sv
// Instruction trace fault logic: flags, pending, fault signalling
//
// Behaviour
// [RULE1] Trace-enable set turns events into faults
// [RULE2] Check pending before each instruction, then fault
// [RULE3] Supervisor call saves enable into frame bit0
// [RULE4] Supervisor call loads enable from stack word
// [RULE5] Supervisor return restores enable from frame
// [RULE6] Instruction mode traces every instruction
// [RULE7] Branch mode traces only taken plain branches
// [RULE8] Call mode traces calls and branch-and-link
// [RULE9] Implicit handler calls also raise call trace
// [RULE10] Call event sets frame prereturn flag bit3
// [RULE11] Return mode traces every return
// [RULE12] Prereturn mode traces flagged returns beforehand
// [RULE13] Prereturn faults after coinciding other event
// [RULE14] Supervisor mode traces supervisor calls and returns
// [RULE15] Breakpoint mode traces plain marker
// [RULE16] Forced marker always raises breakpoint event
// [RULE17] Two message-loaded breakpoint registers match pointers
// [RULE18] Software installs trace handler with tracing off
// [RULE19] Event sets every matching flag and pending
// [RULE20] Faults act only between instructions
// [RULE21] Enable clear: flags set, pending untouched
// [RULE22] Software sets modes then enable, never pending
// [RULE23] Simultaneous events signal highest precedence first
// [RULE24] Pending without enable clears event flags
// [RULE25] Own bit per mode and event, reset clear
module itf_trace_unit
   import itf_pkg::*;
(
   input wire logic clock,              // 200 MHz processor clock
   input wire logic rst_n,              // Synchronous reset, active low
   input wire itf_instr_s instr,        // Retiring instruction info
   input wire logic boundary,           // Next instruction about to start
   input wire itf_tcw_s tc_write,       // Trace-controls modify request
   input wire logic pc_write,           // Software write of process controls
   input wire logic pc_enable_in,       // Enable value written by software
   input wire logic [31:0] ssp_word,    // Supervisor-stack-pointer word
   input wire logic msg_valid,          // Breakpoint message strobe
   input wire logic msg_sel,            // Breakpoint register select
   input wire logic [31:0] msg_ip,      // Breakpoint pointer
   output logic [31:0] trace_controls,  // Internal trace-controls word
   output logic trace_enable,           // Trace-enable flag
   output logic fault_pending,          // Trace-fault-pending flag
   output logic trace_fault,            // One-cycle trace fault signal
   output itf_flags_t fault_kind,       // Highest-precedence event flags
   output logic frame_trace_set,        // Write frame trace bit0 now
   output logic frame_trace_val,        // Value for frame trace bit0
   output logic frame_preret_set        // Set frame prereturn bit3 now
);
   itf_flags_t modes;                   // Mode flags
   itf_flags_t events;                  // Event flags
   itf_flags_t new_events;              // Events from current instruction
   logic new_preret;                    // Prereturn event detected
   logic preret_held;                   // Prereturn deferred behind another
   logic set_preret_flag;               // Frame prereturn request
   logic bkpt_hit;                      // Breakpoint match
   logic sys_super;                     // Supervisor system call
   logic sup_return;                    // Return from supervisor mode
   itf_state_e state;                   // Boundary sequencing state
   itf_flags_t next_kind;               // Precedence selection
   itf_flags_t raised;                  // New events plus prereturn flag
   logic frame_saved;                   // Saved trace bit of return frame

   // Breakpoint registers
   itf_bkpt_regs u_bkpt (
      .clock(clock),
      .rst_n(rst_n),
      .msg_valid(msg_valid),
      .msg_sel(msg_sel),
      .msg_ip(msg_ip),
      .ip(instr.ip),
      .hit(bkpt_hit)
   );

   // Event classifier
   itf_event_detect u_detect (
      .instr(instr),
      .modes(modes),
      .bkpt_hit(bkpt_hit && instr.valid),
      .events(new_events),
      .preret_event(new_preret),
      .set_frame_preret(set_preret_flag)
   );

   // Precedence pick: supervisor, then breakpoint group, then instruction
   // Prereturn is left out: it always gets a fault of its own
   function automatic itf_flags_t pick(input itf_flags_t ev);
      itf_flags_t r;
      itf_flags_t np;
      np = ev & ~(itf_flags_t'(1) << MODE_PRERET);
      r = FLAGS_ZERO;
      if (np[MODE_SUPER]) begin
         r[MODE_SUPER] = 1'b1;
      end else if (np[MODE_BKPT] || np[MODE_BRANCH] || np[MODE_CALL]
                   || np[MODE_RETURN]) begin
         r = np & ~(itf_flags_t'(1) << MODE_INSTR);
      end else begin
         r = np;
      end
      return r;
   endfunction

   // Supervisor call and return detection
   always_comb begin
      sys_super = instr.valid && instr.call_sys && instr.entry_type == ENTRY_SUPER;
      sup_return = instr.valid && instr.ret
         && (instr.ret_status == RSTAT_SUPER_A || instr.ret_status == RSTAT_SUPER_B);
      next_kind = pick(events);                       // see [RULE23]
      raised = new_events;
      raised[MODE_PRERET] = new_preret;               // see [RULE19] [RULE21]
   end

   // Mode flags: software modify only, cleared at reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         modes <= FLAGS_ZERO;                         // see [RULE25]
      end else if (tc_write.valid) begin
         modes <= (modes & ~tc_write.mask[TC_MODE_LSB +: NUM_MODES])
            | (tc_write.data[TC_MODE_LSB +: NUM_MODES]
            & tc_write.mask[TC_MODE_LSB +: NUM_MODES]);
      end
   end

   // Event flags: hardware set wins over any clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         events <= FLAGS_ZERO;                        // see [RULE25]
      end else if (boundary && fault_pending && !trace_enable) begin
         events <= raised;                            // see [RULE24]
      end else if (tc_write.valid) begin
         events <= ((events & ~tc_write.mask[TC_EVENT_LSB +: NUM_MODES])
            | (tc_write.data[TC_EVENT_LSB +: NUM_MODES]
            & tc_write.mask[TC_EVENT_LSB +: NUM_MODES])) | raised;
      end else if (boundary && state == ITF_IDLE && fault_pending
                   && (!preret_held || ~|next_kind)) begin
         events <= raised;                            // Delivered, start fresh
      end else if (boundary && state == ITF_PRERET) begin
         events <= raised;
      end else begin
         events <= events | raised;                   // see [RULE19] [RULE21]
      end
   end

   // Trace-enable: supervisor save/load/restore, software writes
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         trace_enable <= 1'b0;
      end else if (sys_super) begin
         trace_enable <= ssp_word[SSP_TRACE_BIT];      // see [RULE4]
      end else if (sup_return) begin
         trace_enable <= frame_saved;                  // see [RULE5]
      end else if (pc_write) begin
         trace_enable <= pc_enable_in;
      end
   end

   // Copy of enable saved on the most recent supervisor call
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         frame_saved <= 1'b0;
      end else if (sys_super) begin
         frame_saved <= trace_enable;                  // see [RULE3]
      end
   end

   // Frame register write requests
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         frame_trace_set <= 1'b0;
         frame_trace_val <= 1'b0;
         frame_preret_set <= 1'b0;
      end else begin
         frame_trace_set <= sys_super;                 // see [RULE3]
         frame_trace_val <= trace_enable;
         frame_preret_set <= set_preret_flag;          // see [RULE10]
      end
   end

   // Pending flag: set by enabled events, consumed at a boundary
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_pending <= 1'b0;
      end else if (trace_enable && (|new_events || new_preret)) begin
         fault_pending <= 1'b1;                        // see [RULE1] [RULE19] [RULE20]
      end else if (boundary && state == ITF_IDLE && fault_pending) begin
         // A second fault only when a non-prereturn fault goes first
         fault_pending <= preret_held && trace_enable && (|next_kind); // see [RULE13]
      end else if (boundary && state == ITF_PRERET) begin
         fault_pending <= 1'b0;
      end
   end

   // Prereturn held behind another event for a second fault
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         preret_held <= 1'b0;
      end else if (new_preret && trace_enable) begin
         preret_held <= 1'b1;                          // see [RULE12]
      end else if (boundary && state == ITF_PRERET) begin
         preret_held <= 1'b0;
      end else if (boundary && state == ITF_IDLE && fault_pending && ~|next_kind) begin
         preret_held <= 1'b0;                          // Lone prereturn delivered
      end else if (boundary && fault_pending && !trace_enable) begin
         preret_held <= 1'b0;
      end
   end

   // Boundary sequencing and fault signal
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= ITF_IDLE;
         trace_fault <= 1'b0;
         fault_kind <= FLAGS_ZERO;
      end else begin
         trace_fault <= 1'b0;
         case (state)
            ITF_IDLE: begin
               if (boundary && fault_pending && trace_enable) begin
                  trace_fault <= 1'b1;                  // see [RULE2] [RULE20]
                  if (|next_kind) begin
                     fault_kind <= next_kind;           // see [RULE23]
                     if (preret_held) begin
                        state <= ITF_PRERET;            // see [RULE13]
                     end
                  end else begin
                     fault_kind <= itf_flags_t'(1) << MODE_PRERET;
                  end
               end
            end
            ITF_PRERET: begin
               if (boundary && trace_enable) begin
                  trace_fault <= 1'b1;                  // see [RULE13]
                  fault_kind <= itf_flags_t'(1) << MODE_PRERET;
                  state <= ITF_IDLE;
               end else if (boundary) begin
                  state <= ITF_IDLE;
               end
            end
            default: begin
               state <= ITF_IDLE;
            end
         endcase
      end
   end

   // Trace-controls word image
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         trace_controls <= WORD_ZERO;                   // see [RULE25]
      end else begin
         trace_controls <= WORD_ZERO;
         trace_controls[TC_MODE_LSB +: NUM_MODES] <= modes;
         trace_controls[TC_EVENT_LSB +: NUM_MODES] <= events;
      end
   end

   // Pending rises only with an enabled event
   a_pend_cause: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(fault_pending) |-> $past(trace_enable)) // see [RULE21]
      else $error("pending set without enable");
   a_fault_boundary: assert property (@(posedge clock) disable iff (!rst_n)
      trace_fault |-> $past(boundary)) // see [RULE20]
      else $error("fault outside boundary");
   a_fault_pending: assert property (@(posedge clock) disable iff (!rst_n)
      boundary && fault_pending && trace_enable && state == ITF_IDLE |=> trace_fault) // see [RULE2]
      else $error("pending fault not signalled");
   a_preret_twice: assert property (@(posedge clock) disable iff (!rst_n)
      state == ITF_PRERET && boundary && trace_enable |=> trace_fault
      && fault_kind[MODE_PRERET]) // see [RULE13]
      else $error("second prereturn fault missing");
   a_super_load: assert property (@(posedge clock) disable iff (!rst_n)
      sys_super |=> trace_enable == $past(ssp_word[SSP_TRACE_BIT])) // see [RULE4]
      else $error("enable not loaded from stack word");
   a_super_save: assert property (@(posedge clock) disable iff (!rst_n)
      sys_super |=> frame_trace_set && frame_trace_val == $past(trace_enable)) // see [RULE3]
      else $error("enable not saved");
   a_super_restore: assert property (@(posedge clock) disable iff (!rst_n)
      sup_return && !sys_super |=> trace_enable == $past(frame_saved)) // see [RULE5]
      else $error("enable not restored");
   a_instr_event: assert property (@(posedge clock) disable iff (!rst_n)
      instr.valid && modes[MODE_INSTR] && !tc_write.valid |=> events[MODE_INSTR]
      || $past(boundary)) // see [RULE6]
      else $error("instruction event lost");
   a_fmark_event: assert property (@(posedge clock) disable iff (!rst_n)
      instr.valid && instr.fmark |=> events[MODE_BKPT]) // see [RULE16]
      else $error("forced marker event lost");
   a_preret_mark: assert property (@(posedge clock) disable iff (!rst_n)
      instr.valid && instr.bal && modes[MODE_CALL] |=> frame_preret_set) // see [RULE10]
      else $error("prereturn flag not set");
   a_clear_disabled: assert property (@(posedge clock) disable iff (!rst_n)
      boundary && fault_pending && !trace_enable && !instr.valid && !instr.implicit_call
      |=> events == FLAGS_ZERO
      && !trace_fault) // see [RULE24]
      else $error("events not cleared");
   c_fault: cover property (@(posedge clock) disable iff (!rst_n) trace_fault);
   c_double: cover property (@(posedge clock) disable iff (!rst_n)
      trace_fault ##[1:20] trace_fault && fault_kind[MODE_PRERET]);
   c_super: cover property (@(posedge clock) disable iff (!rst_n) sys_super);
   c_bkpt: cover property (@(posedge clock) disable iff (!rst_n) bkpt_hit && instr.valid);
endmodule

// File: itf_trace_unit_bench.sv
// Self-checking bench of the instruction trace fault unit
module itf_trace_unit_bench
   import itf_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock; // Processor clock
   logic rst_n; // Synchronous reset, active low
   itf_instr_s instr; // Retiring instruction
   logic boundary; // Instruction boundary strobe
   itf_tcw_s tc_write; // Trace-controls write
   logic pc_write, pc_enable_in; // Trace-enable write
   logic [31:0] ssp_word; // Supervisor stack word
   logic msg_valid, msg_sel; // Breakpoint message
   logic [31:0] msg_ip; // Breakpoint pointer
   logic [31:0] trace_controls;
   logic trace_enable, fault_pending, trace_fault;
   itf_flags_t fault_kind;
   logic frame_trace_set, frame_trace_val, frame_preret_set;
   int miscompares, samples_checked;
   itf_flags_t exp_q[$]; // Expected fault kinds, oldest first
   logic [15:0] rnd; // Pseudo-random state
   logic [31:0] bp_ip; // Breakpoint pointer in use

   itf_trace_unit u_dut (.clock(clock), .rst_n(rst_n), .instr(instr), .boundary(boundary),
      .tc_write(tc_write), .pc_write(pc_write), .pc_enable_in(pc_enable_in),
      .ssp_word(ssp_word), .msg_valid(msg_valid), .msg_sel(msg_sel), .msg_ip(msg_ip),
      .trace_controls(trace_controls), .trace_enable(trace_enable),
      .fault_pending(fault_pending), .trace_fault(trace_fault), .fault_kind(fault_kind),
      .frame_trace_set(frame_trace_set), .frame_trace_val(frame_trace_val),
      .frame_preret_set(frame_preret_set));

   // Clock of 5 ns period
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Next value of the 16-bit shift register
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Compares one value and counts it
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         miscompares++;
      end
   endtask

   // Prints counts and verdict, then stops
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Watcher: each fault pulse takes the oldest expected kind
   always @(posedge clock) begin
      #1;
      if (trace_fault === 1'b1) begin
         if (exp_q.size() == 0) begin
            check("unexpected trace_fault", 32'h0, 32'h1);
         end else begin
            check("fault_kind", exp_q.pop_front(), fault_kind);
         end
      end
   end

   // Writes the mode flags, events untouched
   task automatic set_modes(input itf_flags_t m);
      @(posedge clock);
      tc_write <= '{valid: 1'b1, mask: 32'h0000_00fe, data: 32'(m) << TC_MODE_LSB};
      @(posedge clock);
      tc_write.valid <= 1'b0;
   endtask

   // Software write of trace-enable
   task automatic set_enable(input logic e);
      @(posedge clock);
      pc_write <= 1'b1;
      pc_enable_in <= e;
      @(posedge clock);
      pc_write <= 1'b0;
   endtask

   // Loads one breakpoint register
   task automatic load_bkpt(input logic s, input logic [31:0] ip);
      @(posedge clock);
      msg_valid <= 1'b1;
      msg_sel <= s;
      msg_ip <= ip;
      @(posedge clock);
      msg_valid <= 1'b0;
   endtask

   // Retires one instruction of kind k; returns when its flags have landed
   task automatic retire(input int k, input logic [31:0] ip);
      itf_instr_s v;
      v = '0;
      v.valid = (k != 9);
      v.ip = ip;
      v.branch_taken = (k == 1);
      v.call = (k == 2);
      v.ret = (k == 3) || (k == 4) || (k == 10) || (k == 11);
      v.frame_preret = (k == 4);
      v.call_sys = (k == 5);
      v.entry_type = (k == 5) ? ENTRY_SUPER : 2'h0;
      v.mark = (k == 6);
      v.fmark = (k == 7);
      v.bal = (k == 8);
      v.implicit_call = (k == 9);
      v.ret_status = (k == 10) ? RSTAT_SUPER_A : ((k == 11) ? RSTAT_SUPER_B : 3'h0);
      @(posedge clock);
      instr <= v;
      @(posedge clock);
      instr <= '0;
      #1;
   endtask

   // Boundary strobe held for n cycles, then waits for expected faults
   task automatic bound(input int n);
      int i;
      @(posedge clock);
      boundary <= 1'b1;
      repeat (n) @(posedge clock);
      boundary <= 1'b0;
      for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clock);
      if (exp_q.size() != 0) begin
         check("fault wait timeout", 32'h0, 32'h1);
         summarize();
      end else begin
         repeat (2) @(posedge clock);
         #1;
      end
   endtask

   // Expects exactly one fault of kind k at the next boundary
   task automatic fault_one(input itf_flags_t k);
      exp_q.push_back(k);
      bound(1);
      check("fault_pending", 32'h0, fault_pending);
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      instr = '0;
      boundary = 1'b0;
      tc_write = '0;
      pc_write = 1'b0;
      pc_enable_in = 1'b0;
      ssp_word = 32'h0000_0001;
      msg_valid = 1'b0;
      msg_sel = 1'b0;
      msg_ip = WORD_ZERO;
      miscompares = 0;
      samples_checked = 0;
      rnd = 16'h6f9f;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("trace_controls", 32'h0, trace_controls);
      check("trace_enable", 32'h0, trace_enable);
      set_modes(7'h7f);
      set_enable(1'b1);
      repeat (2) @(posedge clock);
      #1;
      check("trace_controls", 32'h0000_00fe, trace_controls);
      // One mode at a time, with the instruction kind that matches it
      for (int m = 0; m < NUM_MODES; m++) begin
         set_modes(7'(1 << m));
         rnd = lfsr(rnd);
         retire(m, {16'h0, rnd});
         check("fault_pending", 32'h1, fault_pending);
         if (m == MODE_CALL) check("frame_preret_set", 32'h1, frame_preret_set);
         if (m == MODE_SUPER) check("frame_trace_val", 32'h1, frame_trace_val);
         fault_one(7'(1 << m));
      end
      set_modes(7'h04);
      retire(8, WORD_ZERO);
      check("frame_preret_set", 32'h1, frame_preret_set);
      fault_one(7'h04);
      retire(9, WORD_ZERO);
      fault_one(7'h04);
      // Branch mode ignores untaken branches, links, calls and returns
      set_modes(7'h02);
      for (int k = 0; k < 4; k++) retire((k == 1) ? 8 : k, WORD_ZERO);
      check("fault_pending", 32'h0, fault_pending);
      set_modes(7'h00);
      retire(6, WORD_ZERO);
      check("fault_pending", 32'h0, fault_pending);
      retire(7, WORD_ZERO);
      fault_one(7'h40);
      // Both breakpoint registers, with a near miss first
      set_modes(7'h40);
      for (int s = 0; s < NUM_BKPT; s++) begin
         rnd = lfsr(rnd);
         bp_ip = {rnd, 16'h0010};
         load_bkpt(1'(s), bp_ip);
         retire(0, bp_ip ^ 32'h0000_0004);
         check("fault_pending", 32'h0, fault_pending);
         retire(0, bp_ip);
         fault_one(7'h40);
      end
      // Prereturn coinciding with return: two faults on successive boundaries
      set_modes(7'h18);
      retire(4, WORD_ZERO);
      exp_q.push_back(7'h08);
      exp_q.push_back(7'h10);
      bound(2);
      // Supervisor call saves and loads enable, return restores it
      set_modes(7'h00);
      ssp_word <= WORD_ZERO;
      retire(5, WORD_ZERO);
      check("frame_trace_set", 32'h1, frame_trace_set);
      check("frame_trace_val", 32'h1, frame_trace_val);
      check("trace_enable", 32'h0, trace_enable);
      retire(10, WORD_ZERO);
      check("trace_enable", 32'h1, trace_enable);
      set_modes(7'h20);
      retire(11, WORD_ZERO);
      fault_one(7'h20);
      // Enable clear: flags recorded, no pending
      set_enable(1'b0);
      set_modes(7'h02);
      retire(1, WORD_ZERO);
      check("fault_pending", 32'h0, fault_pending);
      @(posedge clock);
      #1;
      check("branch event", 32'h1, trace_controls[TC_EVENT_LSB + MODE_BRANCH]);
      // Pending with enable clear: events wiped, no fault
      set_enable(1'b1);
      retire(1, WORD_ZERO);
      set_enable(1'b0);
      bound(1);
      check("event flags", 32'h0, trace_controls[TC_EVENT_LSB +: NUM_MODES]);
      summarize();
   end
endmodule
